// file: conv_ctrl_regs.v
/*
  AXI4-Lite register slice for the converter: channel 2 low gain bits,
  isolated power converter control, register map checksum and a range
  status register; also applies the 24-bit gain factor to channel 2.
  Assumes one clock, a synchronous active-low reset, a master keeping at
  most one write and one read in flight, and an upper gain word supplied
  by the neighbouring register.
*/
`timescale 1ns/1ps
`default_nettype none

`include "conv_ctrl_consts.vh"

// Notes on behaviour
// RULE1: Low gain register bits 15:8 hold gain bits 7:0.
// RULE2: Gain factor is unsigned, zero to just under two.
// RULE3: Converter control at index 31h, resets to zero.
// RULE4: Bits 11:8 select modulator clock frequency range.
// RULE5: Code 0000b is 3.76-4.10 MHz, reset value.
// RULE6: Codes 1-3 select the next three ranges.
// RULE7: Code 1111b is 1.40-1.53 MHz, the lowest.
// RULE8: Bit 0 enables the power converter, reset off.
// RULE9: Checksum at index 3Eh, reads zero after reset.
// RULE10: Host writes reserved bits as zero.
// RULE11: Middle codes step down monotonically, overlapping.
module conv_ctrl_regs #(
  parameter ADDR_W = 8  // Byte address width of the register window.
) (
  input  wire              aclk,                   // System clock, 250 MHz.
  input  wire              aresetn,                // Synchronous reset, active low.
  input  wire              ce,                     // Clock enable; all state holds while low.
  input  wire [ADDR_W-1:0] s_axi_awaddr,           // Write address.
  input  wire              s_axi_awvalid,          // Write address valid.
  output reg               s_axi_awready,          // Write address ready.
  input  wire [31:0]       s_axi_wdata,            // Write data.
  input  wire [3:0]        s_axi_wstrb,            // Write byte enables.
  input  wire              s_axi_wvalid,           // Write data valid.
  output reg               s_axi_wready,           // Write data ready.
  output reg  [1:0]        s_axi_bresp,            // Write response code.
  output reg               s_axi_bvalid,           // Write response valid.
  input  wire              s_axi_bready,           // Write response ready.
  input  wire [ADDR_W-1:0] s_axi_araddr,           // Read address.
  input  wire              s_axi_arvalid,          // Read address valid.
  output reg               s_axi_arready,          // Read address ready.
  output reg  [31:0]       s_axi_rdata,            // Read data.
  output reg  [1:0]        s_axi_rresp,            // Read response code.
  output reg               s_axi_rvalid,           // Read data valid.
  input  wire              s_axi_rready,           // Read data ready.
  input  wire [15:0]       ch2_gain_factor_high,   // Upper 16 gain bits from the neighbour.
  input  wire [15:0]       checksum_value,         // Freshly computed map checksum.
  input  wire              checksum_update,        // Pulse: load checksum_value.
  input  wire signed [15:0] ch2_sample,            // Channel 2 conversion result.
  input  wire              ch2_sample_valid,       // Pulse: ch2_sample is new.
  output reg  [23:0]       ch2_gain_factor,        // Assembled 24-bit gain factor.
  output reg  signed [15:0] ch2_corrected,         // Gain corrected sample.
  output reg               ch2_corrected_valid,    // Pulse: ch2_corrected is new.
  output reg               converter_enable,       // Power converter on when high.
  output reg  [3:0]        converter_freq_range,   // Selected frequency range code.
  output wire [8:0]        range_min,              // Selected range floor, 10 kHz units.
  output wire [8:0]        range_max               // Selected range ceiling, 10 kHz units.
);

  // Stored registers.
  reg [7:0]        ch2_gain_factor_low_bits;  // Gain bits 7:0.
  reg [15:0]       power_converter_control;   // Full control word.
  reg [15:0]       register_map_checksum;     // Last loaded checksum.

  // Captured write request.
  reg              aw_held;                   // Write address has been taken.
  reg [ADDR_W-1:0] aw_addr;                   // Taken write address.
  reg              w_held;                    // Write data has been taken.
  reg [31:0]       w_data;                    // Taken write data.
  reg [3:0]        w_strb;                    // Taken byte enables.

  // Decode helper: true when a byte address hits the given register index.
  function hit;
    input [ADDR_W-1:0] addr;
    input [5:0]        index;
    begin
      hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == index);
    end
  endfunction

  // Byte lane merge of a 16-bit register with new data under two strobes.
  function [15:0] merge16;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? new_val[7:0]  : old_val[7:0];
      merge16[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
    end
  endfunction

  // A write happens once both halves are held and no response is pending.
  wire do_write = aw_held && w_held && !s_axi_bvalid;

  // Decoded targets of the pending write.
  wire wr_gain    = hit(aw_addr, `IDX_CH2_GAIN_FACTOR_LOW);
  wire wr_control = hit(aw_addr, `IDX_POWER_CONVERTER_CONTROL);
  wire wr_known   = wr_gain || wr_control ||
                    hit(aw_addr, `IDX_REGISTER_MAP_CHECKSUM) ||
                    hit(aw_addr, `IDX_CONVERTER_RANGE_STATUS);

  // Merged control word, used by the register and its output copies.
  wire [15:0] next_control = merge16(power_converter_control, w_data[15:0], w_strb[1:0]);

  // Merged gain word; only the upper byte is stored.
  wire [15:0] next_gain_word = merge16({ch2_gain_factor_low_bits, 8'h00},
                                       w_data[15:0], w_strb[1:0]);

  // Write address and data channels, each accepted on its own; the response
  // reopens both, so a second write cannot overtake the first.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_held        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else if (ce) begin
      // Take the address and close the channel until the response is done.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      // Take the data likewise, in whichever order it arrives.
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // Both halves present: answer; unmapped offsets get an error.
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      // Response taken: release the held request and reopen both channels.
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register storage. The control word keeps its reserved bits as written,
  // since they are read-write; the host is expected to write them as zero.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ch2_gain_factor_low_bits <= 8'h00;
      power_converter_control  <= `RST_POWER_CONVERTER_CONTROL; // RULE3
      converter_enable         <= 1'b0;                          // RULE8
      converter_freq_range     <= `FREQ_CODE_HIGHEST;            // RULE5
    end else if (ce && do_write) begin
      // Gain register: only bits 15:8 are kept; bits 7:0 are reserved.
      if (wr_gain) begin
        ch2_gain_factor_low_bits <= next_gain_word[`GAIN_LOW_BITS_MSB:`GAIN_LOW_BITS_LSB]; // RULE1
      end
      // Control register: update the word and its decoded fields together.
      if (wr_control) begin
        power_converter_control <= next_control; // RULE10
        converter_freq_range    <= next_control[`FREQ_RANGE_MSB:`FREQ_RANGE_LSB]; // RULE4
        converter_enable        <= next_control[`CONVERTER_ENABLE_BIT]; // RULE8
      end
    end
  end

  // Checksum is read only from the bus; it loads only on the update pulse.
  always @(posedge aclk) begin
    if (!aresetn) begin
      register_map_checksum <= `RST_REGISTER_MAP_CHECKSUM; // RULE9
    end else if (ce && checksum_update) begin
      register_map_checksum <= checksum_value;
    end
  end

  // Read data mux, decoded straight from the request address.
  reg [31:0] next_rdata;  // Data for the addressed register.
  reg        next_rerr;   // Address hits no register.
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    if (hit(s_axi_araddr, `IDX_CH2_GAIN_FACTOR_LOW)) begin
      // Reserved low byte reads as zero.
      next_rdata = {16'h0000, ch2_gain_factor_low_bits, 8'h00}; // RULE1
    end else if (hit(s_axi_araddr, `IDX_POWER_CONVERTER_CONTROL)) begin
      next_rdata = {16'h0000, power_converter_control}; // RULE3
    end else if (hit(s_axi_araddr, `IDX_REGISTER_MAP_CHECKSUM)) begin
      next_rdata = {16'h0000, register_map_checksum}; // RULE9
    end else if (hit(s_axi_araddr, `IDX_CONVERTER_RANGE_STATUS)) begin
      // Floor in the upper half, ceiling in the lower half.
      next_rdata = {7'h00, range_min, 7'h00, range_max};
    end else begin
      next_rerr = 1'b1;
    end
  end

  // Read channel: one request in flight, answered the cycle after it is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        // Data stands until taken; then the address channel reopens.
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Range lookup for the selected code, registered inside.
  freq_range_table u_range (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .code      (converter_freq_range),
    .range_min (range_min),
    .range_max (range_max)
  );

  // Gain correction: the factor is an unsigned fixed-point value with one
  // integer bit, so the product is shifted right by the fraction width.
  // Gains near two can overflow 16 bits, so the result saturates rather
  // than wrapping, which would flip the sign of a large sample.
  wire signed [40:0] product = ch2_sample * $signed({1'b0, ch2_gain_factor}); // RULE2
  wire               ovf     = (product[40:38] != 3'b000) && (product[40:38] != 3'b111);
  wire signed [15:0] scaled  = product[38:`GAIN_FRAC_BITS];

  // Assemble the gain factor and apply it one cycle after each sample.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ch2_gain_factor     <= 24'h000000;
      ch2_corrected       <= 16'h0000;
      ch2_corrected_valid <= 1'b0;
    end else if (ce) begin
      ch2_gain_factor     <= {ch2_gain_factor_high, ch2_gain_factor_low_bits}; // RULE1
      ch2_corrected_valid <= ch2_sample_valid;
      if (ch2_sample_valid) begin
        if (ovf) begin
          ch2_corrected <= product[40] ? 16'h8000 : 16'h7fff; // RULE2
        end else begin
          ch2_corrected <= scaled;
        end
      end
    end
  end

endmodule // conv_ctrl_regs

`default_nettype wire

// file: conv_ctrl_consts.vh
/*
  Shared constants for the converter control register slice: register
  indices, field positions, reset values and bus response codes.
  Assumes it is included by its bare name and holds definitions only.
*/
`ifndef CONV_CTRL_CONSTS_VH
`define CONV_CTRL_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_CH2_GAIN_FACTOR_LOW      6'h17
`define IDX_CONVERTER_RANGE_STATUS   6'h30
`define IDX_POWER_CONVERTER_CONTROL  6'h31
`define IDX_REGISTER_MAP_CHECKSUM    6'h3e

// Reset values of the registers.
`define RST_CH2_GAIN_FACTOR_LOW      16'h0000
`define RST_POWER_CONVERTER_CONTROL  16'h0000
`define RST_REGISTER_MAP_CHECKSUM    16'h0000

// Field positions.
`define GAIN_LOW_BITS_MSB            15
`define GAIN_LOW_BITS_LSB            8
`define FREQ_RANGE_MSB               11
`define FREQ_RANGE_LSB               8
`define CONVERTER_ENABLE_BIT         0

// Frequency range codes at the two ends of the table.
`define FREQ_CODE_HIGHEST            4'h0
`define FREQ_CODE_LOWEST             4'hf

// Gain factor: 24 bits, one integer bit and 23 fraction bits.
`define GAIN_FRAC_BITS               23

// Bus response codes.
`define RESP_OKAY                    2'h0
`define RESP_SLVERR                  2'h2

`endif

// file: freq_range_table.v
/*
  Lookup of the modulator clock frequency range selected by a 4-bit code.
  Limits are given in units of 10 kHz. Assumes a synchronous active-low
  reset and a clock enable shared with the register slice.
*/
`timescale 1ns/1ps
`default_nettype none

module freq_range_table (
  input  wire       aclk,       // System clock.
  input  wire       aresetn,    // Synchronous reset, active low.
  input  wire       ce,         // Clock enable; state holds while low.
  input  wire [3:0] code,       // Selected frequency range code.
  output reg  [8:0] range_min,  // Lower limit in 10 kHz units.
  output reg  [8:0] range_max   // Upper limit in 10 kHz units.
);

  // Table of limits; the middle codes step down monotonically and overlap.
  function [17:0] limits;
    input [3:0] c;
    begin
      case (c)
        4'h0:    limits = {9'd376, 9'd410}; // RULE5
        4'h1:    limits = {9'd352, 9'd384}; // RULE6
        4'h2:    limits = {9'd330, 9'd359}; // RULE6
        4'h3:    limits = {9'd309, 9'd336}; // RULE6
        4'h4:    limits = {9'd289, 9'd315}; // RULE11
        4'h5:    limits = {9'd271, 9'd295}; // RULE11
        4'h6:    limits = {9'd253, 9'd276}; // RULE11
        4'h7:    limits = {9'd237, 9'd259}; // RULE11
        4'h8:    limits = {9'd222, 9'd242}; // RULE11
        4'h9:    limits = {9'd208, 9'd227}; // RULE11
        4'ha:    limits = {9'd195, 9'd212}; // RULE11
        4'hb:    limits = {9'd183, 9'd198}; // RULE11
        4'hc:    limits = {9'd171, 9'd186}; // RULE11
        4'hd:    limits = {9'd160, 9'd174}; // RULE11
        4'he:    limits = {9'd150, 9'd163}; // RULE11
        4'hf:    limits = {9'd140, 9'd153}; // RULE7
        default: limits = {9'd376, 9'd410};
      endcase
    end
  endfunction

  wire [17:0] next_limits = limits(code); // Decoded pair for the current code.

  // Register the limits so that the outputs come from flip-flops.
  always @(posedge aclk) begin
    if (!aresetn) begin
      range_min <= 9'd376;
      range_max <= 9'd410;
    end else if (ce) begin
      range_min <= next_limits[17:9];
      range_max <= next_limits[8:0];
    end
  end

endmodule // freq_range_table

`default_nettype wire

// file: conv_ctrl_regs_assertions.sv
/*
  Concurrent checks on the ports of the converter control register slice.
  Assumes one clock, a synchronous active-low reset, and ce high whenever
  the bus, the samples or the upper gain word move.
*/
`timescale 1ns/1ps
`default_nettype none

module conv_ctrl_regs_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [15:0] ch2_gain_factor_high,
  input wire logic        ch2_sample_valid,
  input wire logic [23:0] ch2_gain_factor,
  input wire logic        ch2_corrected_valid,
  input wire logic        converter_enable,
  input wire logic [3:0]  converter_freq_range,
  input wire logic [8:0]  range_min,
  input wire logic [8:0]  range_max
);
  // Everything here belongs to the one clock domain.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Limits of the three codes just below the top range, 10 kHz units.
  function automatic logic [17:0] mid_range(input logic [3:0] c);
    case (c)
      4'h1: return {9'h160, 9'h180};
      4'h2: return {9'h14a, 9'h167};
      default: return {9'h135, 9'h150};
    endcase
  endfunction

  // A write is taken with address and data in the same cycle.
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // The slave closes its ready lines, then answers one cycle later.
  sequence wr_answer;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  AST_WRITE_ANSWER: assert property (wr_take |=> wr_answer)
    else $error("write answer timing wrong");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer timing wrong");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RESET_CTRL: assert property ($rose(aresetn) |-> !converter_enable && converter_freq_range == 4'h0)
    else $error("control outputs not cleared by reset");
  AST_RANGE_TOP: assert property (converter_freq_range == 4'h0 |=> range_min == 9'h178 && range_max == 9'h19a)
    else $error("top range limits wrong");
  AST_RANGE_NEXT: assert property (converter_freq_range inside {[4'h1:4'h3]} |=> {range_min, range_max} == mid_range($past(converter_freq_range)))
    else $error("upper middle range limits wrong");
  AST_RANGE_LOW: assert property (converter_freq_range == 4'hf |=> range_min == 9'h08c && range_max == 9'h099)
    else $error("lowest range limits wrong");
  AST_RANGE_ORDER: assert property (range_min < range_max)
    else $error("range floor not below ceiling");
  AST_GAIN_JOIN: assert property ($past(aresetn) |-> ch2_gain_factor[23:8] == $past(ch2_gain_factor_high))
    else $error("gain upper bits not joined");
  AST_CORR_PULSE: assert property ($past(aresetn) |-> ch2_corrected_valid == $past(ch2_sample_valid))
    else $error("corrected sample pulse misplaced");
  // Control outputs may only move on the edge that raises the write answer.
  AST_CTRL_BY_WRITE: assert property (($changed(converter_enable) || $changed(converter_freq_range)) && $past(aresetn) |-> $rose(s_axi_bvalid))
    else $error("control output moved without a write");
endmodule // conv_ctrl_regs_checker

bind conv_ctrl_regs conv_ctrl_regs_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .ch2_gain_factor_high, .ch2_sample_valid, .ch2_gain_factor,
  .ch2_corrected_valid, .converter_enable, .converter_freq_range, .range_min, .range_max);

`default_nettype wire

// file: tb_conv_ctrl_regs.sv
/*
  Self-checking bench for the converter control register slice, with a
  register model and a gain model. Assumes the checker file is compiled too.
*/
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_consts.vh"

module tb_conv_ctrl_regs;
  localparam logic [7:0] A_CTL  = {`IDX_POWER_CONVERTER_CONTROL, 2'b00};
  localparam logic [7:0] A_GAIN = {`IDX_CH2_GAIN_FACTOR_LOW, 2'b00};
  localparam logic [7:0] A_SUM  = {`IDX_REGISTER_MAP_CHECKSUM, 2'b00};
  localparam logic [7:0] A_RNG  = {`IDX_CONVERTER_RANGE_STATUS, 2'b00};
  // Range limits per code in 10 kHz units; middle codes follow the chosen table.
  logic [8:0] lo [16] = '{9'h178, 9'h160, 9'h14a, 9'h135, 9'h121, 9'h10f, 9'h0fd, 9'h0ed,
                          9'h0de, 9'h0d0, 9'h0c3, 9'h0b7, 9'h0ab, 9'h0a0, 9'h096, 9'h08c};
  logic [8:0] hi [16] = '{9'h19a, 9'h180, 9'h167, 9'h150, 9'h13b, 9'h127, 9'h114, 9'h103,
                          9'h0f2, 9'h0e3, 9'h0d4, 9'h0c6, 9'h0ba, 9'h0ae, 9'h0a3, 9'h099};
  logic               aclk = 0, aresetn = 0, ce = 1;
  logic [7:0]         s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]        s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]         s_axi_wstrb = 0, converter_freq_range;
  logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic               s_axi_arvalid = 0, s_axi_rready = 0, checksum_update = 0;
  logic               ch2_sample_valid = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic               s_axi_arready, s_axi_rvalid, ch2_corrected_valid, converter_enable;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [15:0]        ch2_gain_factor_high = 16'h8000, checksum_value = 0;
  logic signed [15:0] ch2_sample = 0, ch2_corrected;
  logic [23:0]        ch2_gain_factor;
  logic [8:0]         range_min, range_max;
  logic [15:0]        ctrl_model = 0;  // Expected control register.
  logic [7:0]         gain_low = 0;    // Expected low gain byte.
  int                 seed = 32'h8c8f8c69, error_cnt = 0, num_checks = 0;

  conv_ctrl_regs #(.ADDR_W(8)) i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch2_gain_factor_high, .checksum_value,
    .checksum_update, .ch2_sample, .ch2_sample_valid, .ch2_gain_factor, .ch2_corrected,
    .ch2_corrected_valid, .converter_enable, .converter_freq_range, .range_min, .range_max);

  // 250 MHz clock.
  always #2 aclk = ~aclk;

  // One comparison; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write with a randomly late bready, so the slave must hold its answer.
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] exp);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= $random(seed) % 2 != 0;
    end while (!(s_axi_bvalid && s_axi_bready));
    chk({30'h0, s_axi_bresp}, {30'h0, exp});
    s_axi_bready <= 1'b0;
  endtask

  // Read with a randomly late rready, then compare data and response.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= $random(seed) % 2 != 0;
    end while (!(s_axi_rvalid && s_axi_rready));
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs a few hundred cycles.
  initial begin
    #80000;
    error_cnt++;
    conclude();
  end

  // Main sequence.
  initial begin
    logic [15:0] v;
    logic [3:0]  s;
    longint      p;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(A_CTL, 32'h0, 2'h0);
    rdc(A_SUM, 32'h0, 2'h0);
    rdc(A_GAIN, 32'h0, 2'h0);
    // Every range code, random enable and low-byte strobe; reserved bits zero.
    for (int c = 0; c < 16; c++) begin
      v = {4'h0, c[3:0], 7'h0, 1'($random(seed))};
      s = {3'b001, 1'($random(seed))};
      wrc(A_CTL, {16'h0, v}, s, 2'h0);
      ctrl_model[15:8] = v[15:8];
      if (s[0]) ctrl_model[7:0] = v[7:0];
      rdc(A_CTL, {16'h0, ctrl_model}, 2'h0);
      chk({28'h0, converter_freq_range}, {28'h0, ctrl_model[11:8]});
      chk({31'h0, converter_enable}, {31'h0, ctrl_model[0]});
      chk({7'h0, range_min, 7'h0, range_max}, {7'h0, lo[c], 7'h0, hi[c]});
      rdc(A_RNG, {7'h0, lo[c], 7'h0, hi[c]}, 2'h0);
    end
    // Low gain byte and the gain applied to samples, saturating at both ends.
    for (int i = 0; i < 10; i++) begin
      v = 16'($random(seed));
      s = 4'($random(seed));
      ch2_gain_factor_high <= (i == 0) ? 16'hffff : 16'($random(seed));
      wrc(A_GAIN, {16'h0, v}, s, 2'h0);
      if (s[1]) gain_low = v[15:8];
      rdc(A_GAIN, {16'h0, gain_low, 8'h00}, 2'h0);
      chk({8'h0, ch2_gain_factor}, {8'h0, ch2_gain_factor_high, gain_low});
      ch2_sample <= (i == 1) ? -16'sh8000 : 16'($random(seed));
      ch2_sample_valid <= 1'b1;
      @(posedge aclk);
      ch2_sample_valid <= 1'b0;
      p = (longint'(ch2_sample) * longint'({ch2_gain_factor_high, gain_low})) >>> 23;
      if (p > 64'sh7fff) p = 64'sh7fff;
      if (p < -64'sh8000) p = -64'sh8000;
      @(posedge aclk);
      chk({16'h0, ch2_corrected}, {16'h0, p[15:0]});
      chk({31'h0, ch2_corrected_valid}, 32'h1);
    end
    // Checksum loads from its input and ignores bus writes.
    v = 16'($random(seed));
    checksum_value <= v;
    checksum_update <= 1'b1;
    @(posedge aclk);
    checksum_update <= 1'b0;
    rdc(A_SUM, {16'h0, v}, 2'h0);
    // With the clock enable low an update pulse must not load.
    ce <= 1'b0;
    checksum_value <= ~v;
    checksum_update <= 1'b1;
    repeat (4) @(posedge aclk);
    checksum_update <= 1'b0;
    ce <= 1'b1;
    rdc(A_SUM, {16'h0, v}, 2'h0);
    wrc(A_SUM, 32'h0000_1234, 4'h3, 2'h0);
    rdc(A_SUM, {16'h0, v}, 2'h0);
    // Unmapped and unaligned places are refused and leave control alone.
    wrc(8'h04, 32'h0000_0f01, 4'h3, 2'h2);
    rdc(8'h04, 32'h0, 2'h2);
    rdc(A_CTL + 8'h1, 32'h0, 2'h2);
    rdc(A_CTL, {16'h0, ctrl_model}, 2'h0);
    // A second reset in mid-run clears control again.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({27'h0, converter_enable, converter_freq_range}, 32'h0);
    chk({7'h0, range_min, 7'h0, range_max}, {7'h0, lo[0], 7'h0, hi[0]});
    rdc(A_CTL, 32'h0, 2'h0);
    conclude();
  end
endmodule // tb_conv_ctrl_regs

`default_nettype wire
